/* File: include/wdit_pkg.sv */
// Package for the watchdog / interval timer: offsets, fields, resets, timing
package wdit_pkg;
    // ----------------------------------------
    // Addresses (lower 16 bits)
    // ----------------------------------------
    localparam logic [15:0] ADDR_CTRL_WR   = 16'hFFA8;
    localparam logic [15:0] ADDR_RSTCS_WR  = 16'hFFAA;
    localparam logic [15:0] ADDR_CTRL_RD   = 16'hFFA8;
    localparam logic [15:0] ADDR_CNT_RD    = 16'hFFA9;
    localparam logic [15:0] ADDR_RSTCS_RD  = 16'hFFAB;
    // ----------------------------------------
    // Passwords and clear value
    // ----------------------------------------
    localparam logic [7:0] PW_COUNTER      = 8'h5A;
    localparam logic [7:0] PW_CONTROL      = 8'hA5;
    localparam logic [7:0] RST_CLEAR_DATA  = 8'h00;
    // ----------------------------------------
    // Field positions
    // ----------------------------------------
    localparam int OVF_BIT    = 7;
    localparam int MODE_BIT   = 6;
    localparam int ENABLE_BIT = 5;
    localparam int CKS_MSB    = 2;
    localparam int WATCHDOG_RESET_FLAG_BIT   = 7;
    localparam int RESET_OUTPUT_ENABLE_BIT  = 6;
    // ----------------------------------------
    // Reset values
    // ----------------------------------------
    localparam logic [7:0] CTRL_RESET   = 8'h18;
    localparam logic [7:0] CNT_RESET    = 8'h00;
    localparam logic [7:0] RSTCS_RESET  = 8'h3F;
    localparam logic [1:0] CTRL_RSVD    = 2'b11;
    localparam logic [5:0] RSTCS_RSVD   = 6'h3F;
    // ----------------------------------------
    // Timing (states = system clock cycles)
    // ----------------------------------------
    localparam int INT_RESET_STATES = 518;
    localparam int OUT_RESET_STATES = 132;
    localparam int PRESCALE_BITS    = 12;

    typedef struct packed {
        logic        wr;
        logic        word;
        logic        rd;
        logic [15:0] addr;
        logic [15:0] wdata;
    } wdit_bus_t;
endpackage

/* File: rtl/wdit_timer.sv */
// Watchdog / interval timer with password-protected registers
// Notes on behaviour
// - Three-bit select picks one of eight taps
// - Counter increments on tap while enabled
// - Wrap FF to 00 sets overflow flag
// - Counter zero on reset or disabled
// - Overflow clears after read-one then write-zero
// - Mode bit picks interrupt or reset
// - Reserved bits 4,3 read one
// - Bits 7..5 clear on reset, standby
// - Clock select cleared only by reset
// - Bit 7 accepts only zero writes
// - Word writes at FFA8/FFAA, byte reads decoded
// - Watchdog overflow resets chip, optional pin
// - Dedicated reset output pin
// - Reset values 18, 00, 3F
// - Password A5/5A selects control or counter
// - A5 00 clears flag, 5A writes enable
// - Internal reset 518, pin 132 states
// - Reset flag survives internal reset
`timescale 1ns/10ps
module wdit_timer (
    input  wire logic                  i_clk,
    input  wire logic                  i_rst_b,
    input  wire logic                  i_standby,
    input  wire wdit_pkg::wdit_bus_t   i_bus,
    output logic [7:0]                 o_rdata,
    output logic                       o_irq,
    output logic                       o_chip_reset,
    output logic                       o_reset_output_pin_b
);
    // ----------------------------------------
    // State
    // ----------------------------------------
    logic [wdit_pkg::PRESCALE_BITS-1:0] presc_r;
    logic [7:0]  wdog_counter_r;
    logic        overflow_flag_r;
    logic        timer_mode_r;
    logic        timer_enable_r;
    logic [2:0]  clock_select_r;
    logic        watchdog_reset_flag_r;
    logic        reset_output_enable_r;
    logic        ovf_seen_r;
    logic [9:0]  int_cnt_r;
    logic [7:0]  out_cnt_r;
    logic        tick;
    logic        wrap;
    logic        wr_ctrl;
    logic        wr_cnt;
    logic        wr_rst_clr;
    logic        wr_rst_oe;
    logic        internal_clear;
    logic [7:0]  ctrl_view;
    logic [7:0]  rstcs_view;
    logic [wdit_pkg::PRESCALE_BITS-1:0] presc_nxt;
    logic        wr_word;
    logic [7:0]  wr_password;
    logic [7:0]  wr_payload;
    logic        wdog_fire;
    logic        ctrl_clear;
    logic        rd_ctrl;
    logic        rd_cnt;
    logic        rd_rstcs;
    logic        ovf_read_one;
    logic        ovf_clear;
    logic [7:0]  rd_mux;

    // ----------------------------------------
    // Prescaler and tap select
    // ----------------------------------------
    // Free running so a tap change never restarts it
    // A tap change while enabled can cut the first period short
    assign presc_nxt = presc_r + 12'h001;
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            presc_r <= '0;
        end else begin
            presc_r <= presc_nxt;
        end
    end

    // Tick on the bit's rising edge: one pulse per divided period
    always_comb begin
        case (clock_select_r)
            3'd0:    tick = presc_nxt[0]  & ~presc_r[0];
            3'd1:    tick = presc_nxt[4]  & ~presc_r[4];
            3'd2:    tick = presc_nxt[5]  & ~presc_r[5];
            3'd3:    tick = presc_nxt[6]  & ~presc_r[6];
            3'd4:    tick = presc_nxt[7]  & ~presc_r[7];
            3'd5:    tick = presc_nxt[8]  & ~presc_r[8];
            3'd6:    tick = presc_nxt[10] & ~presc_r[10];
            default: tick = presc_nxt[11] & ~presc_r[11];
        endcase
    end

    // ----------------------------------------
    // Write decode
    // ----------------------------------------
    // Byte writes are dropped: password needs the full word
    always_comb begin
        wr_ctrl    = 1'b0;
        wr_cnt     = 1'b0;
        wr_rst_clr = 1'b0;
        wr_rst_oe  = 1'b0;
        if (wr_word && i_bus.addr == wdit_pkg::ADDR_CTRL_WR) begin
            wr_ctrl = (wr_password == wdit_pkg::PW_CONTROL);
            wr_cnt  = (wr_password == wdit_pkg::PW_COUNTER);
        end else if (wr_word && i_bus.addr == wdit_pkg::ADDR_RSTCS_WR) begin
            wr_rst_clr = (wr_password == wdit_pkg::PW_CONTROL)
                       && (wr_payload == wdit_pkg::RST_CLEAR_DATA);
            wr_rst_oe  = (wr_password == wdit_pkg::PW_COUNTER);
        end
    end

    // ----------------------------------------
    // Access fields
    // ----------------------------------------
    assign wr_word     = i_bus.wr && i_bus.word;
    assign wr_password = i_bus.wdata[15:8];
    assign wr_payload  = i_bus.wdata[7:0];

    // ----------------------------------------
    // Overflow sources
    // ----------------------------------------
    // Standby or internal reset masks a wrap so neither fires a reset
    assign wrap = timer_enable_r && tick && (wdog_counter_r == 8'hFF) && !wr_cnt
                  && !i_standby && !internal_clear;
    // Internal reset clears the timer registers, but not the reset register or the prescaler
    assign internal_clear = o_chip_reset;
    assign ctrl_clear     = internal_clear || i_standby;
    // Overflow in watchdog mode starts the internal reset pulse and, when the reset output is enabled, the pin pulse
    assign wdog_fire      = wrap && timer_mode_r;
    // Clear is armed by a read of one, then taken by a write of zero
    assign ovf_read_one   = rd_ctrl && overflow_flag_r;
    assign ovf_clear      = wr_ctrl && ovf_seen_r && !wr_payload[wdit_pkg::OVF_BIT];

    // ----------------------------------------
    // Counter
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            wdog_counter_r <= wdit_pkg::CNT_RESET;
        // Disabled counter is pinned at zero, not frozen
        end else if (ctrl_clear || !timer_enable_r) begin
            wdog_counter_r <= wdit_pkg::CNT_RESET;
        end else if (wr_cnt) begin
            // Write beats a coincident count
            wdog_counter_r <= i_bus.wdata[7:0];
        end else if (tick) begin
            wdog_counter_r <= wdog_counter_r + 8'h01;
        end
    end

    // ----------------------------------------
    // Control/status
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            timer_mode_r   <= 1'b0;
            timer_enable_r <= 1'b0;
        end else if (ctrl_clear) begin
            timer_mode_r   <= 1'b0;
            timer_enable_r <= 1'b0;
        end else if (wr_ctrl) begin
            timer_mode_r   <= i_bus.wdata[wdit_pkg::MODE_BIT];
            timer_enable_r <= i_bus.wdata[wdit_pkg::ENABLE_BIT];
        end
    end

    // Standby keeps the select; only resets clear it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            clock_select_r <= 3'b000;
        end else if (internal_clear) begin
            clock_select_r <= 3'b000;
        end else if (wr_ctrl) begin
            clock_select_r <= i_bus.wdata[wdit_pkg::CKS_MSB:0];
        end
    end

    // Set wins over clear; clear only after a read of one
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            overflow_flag_r <= 1'b0;
            ovf_seen_r      <= 1'b0;
        end else if (ctrl_clear) begin
            overflow_flag_r <= 1'b0;
            ovf_seen_r      <= 1'b0;
        end else if (wrap) begin
            overflow_flag_r <= 1'b1;
        end else begin
            if (ovf_read_one) begin
                ovf_seen_r <= 1'b1;
            end
            if (ovf_clear) begin
                overflow_flag_r <= 1'b0;
                ovf_seen_r      <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Reset control/status
    // ----------------------------------------
    // Only the pin reset clears these, never the internal one
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            watchdog_reset_flag_r <= 1'b0;
            reset_output_enable_r <= 1'b0;
        end else begin
            // Overflow wins over a coincident clear write
            if (wdog_fire) begin
                watchdog_reset_flag_r <= 1'b1;
            end else if (wr_rst_clr) begin
                watchdog_reset_flag_r <= 1'b0;
            end
            if (wr_rst_oe) begin
                reset_output_enable_r <= i_bus.wdata[wdit_pkg::RESET_OUTPUT_ENABLE_BIT];
            end
        end
    end

    // ----------------------------------------
    // Reset pulse generation
    // ----------------------------------------
    // Pulse lengths count from the overflow edge itself
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            int_cnt_r    <= '0;
            o_chip_reset <= 1'b0;
        end else if (wdog_fire) begin
            int_cnt_r    <= 10'(wdit_pkg::INT_RESET_STATES - 1);
            o_chip_reset <= 1'b1;
        end else if (int_cnt_r != '0) begin
            int_cnt_r <= int_cnt_r - 10'd1;
        end else begin
            o_chip_reset <= 1'b0;
        end
    end

    // Pin pulse is shorter and only drives low when enabled
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_cnt_r            <= '0;
            o_reset_output_pin_b <= 1'b1;
        end else if (wdog_fire) begin
            out_cnt_r            <= 8'(wdit_pkg::OUT_RESET_STATES - 1);
            o_reset_output_pin_b <= !reset_output_enable_r;
        end else if (out_cnt_r != '0) begin
            out_cnt_r <= out_cnt_r - 8'd1;
        end else begin
            o_reset_output_pin_b <= 1'b1;
        end
    end

    // ----------------------------------------
    // Interrupt and read data
    // ----------------------------------------
    // Level request: it drops when the flag clears or when watchdog mode is selected
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_irq <= 1'b0;
        end else begin
            o_irq <= (overflow_flag_r || wrap) && !timer_mode_r && !internal_clear;
        end
    end

    assign ctrl_view  = {overflow_flag_r, timer_mode_r, timer_enable_r,
                         wdit_pkg::CTRL_RSVD, clock_select_r};
    assign rstcs_view = {watchdog_reset_flag_r, reset_output_enable_r,
                         wdit_pkg::RSTCS_RSVD};

    // ----------------------------------------
    // Read decode
    // ----------------------------------------
    // Byte reads at their own addresses; the write-only word reads as zero
    assign rd_ctrl  = i_bus.rd && i_bus.addr == wdit_pkg::ADDR_CTRL_RD;
    assign rd_cnt   = i_bus.rd && i_bus.addr == wdit_pkg::ADDR_CNT_RD;
    assign rd_rstcs = i_bus.rd && i_bus.addr == wdit_pkg::ADDR_RSTCS_RD;

    always_comb begin
        if (rd_ctrl) begin
            rd_mux = ctrl_view;
        end else if (rd_cnt) begin
            rd_mux = wdog_counter_r;
        end else if (rd_rstcs) begin
            rd_mux = rstcs_view;
        end else begin
            rd_mux = 8'h00;
        end
    end

    // Registered read: data one cycle after the read strobe
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= 8'h00;
        end else if (i_bus.rd) begin
            o_rdata <= rd_mux;
        end
    end
endmodule

/* File: verification/wdit_timer_assertions.sv */
// Checker for the watchdog / interval timer port behaviour
`timescale 1ns/10ps
module wdit_timer_assertions (
    input wire logic                i_clk,
    input wire logic                i_rst_b,
    input wire logic                i_standby,
    input wire wdit_pkg::wdit_bus_t i_bus,
    input wire logic [7:0]          o_rdata,
    input wire logic                o_irq,
    input wire logic                o_chip_reset,
    input wire logic                o_reset_output_pin_b
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    logic [9:0] cr_len_r;
    logic [9:0] pin_len_r;
    logic       rd_ctrl;
    logic       rd_rst;
    logic       rd_none;
    assign rd_ctrl = i_bus.rd && i_bus.addr == wdit_pkg::ADDR_CTRL_RD;
    assign rd_rst  = i_bus.rd && i_bus.addr == wdit_pkg::ADDR_RSTCS_RD;
    assign rd_none = i_bus.rd && !rd_ctrl && !rd_rst && i_bus.addr != wdit_pkg::ADDR_CNT_RD;
    // ----------------------------------------
    // Pulse length counters, too long to unroll
    // ----------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) cr_len_r <= '0;
        else cr_len_r <= o_chip_reset ? cr_len_r + 10'd1 : '0;
    end
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) pin_len_r <= '0;
        else pin_len_r <= !o_reset_output_pin_b ? pin_len_r + 10'd1 : '0;
    end
    // ----------------------------------------
    // Assertions
    // ----------------------------------------
    chk_chip_rst_len: assert property ($fell(o_chip_reset) |-> cr_len_r == 10'd518)
        else $error("internal reset pulse length wrong");
    chk_pin_low_len: assert property ($rose(o_reset_output_pin_b) |-> pin_len_r == 10'd132)
        else $error("reset output pin low length wrong");
    chk_pin_with_reset: assert property ($fell(o_reset_output_pin_b) |-> $rose(o_chip_reset))
        else $error("reset output pin not tied to internal reset");
    chk_irq_no_wdog: assert property (o_irq |-> !o_chip_reset)
        else $error("interrupt during watchdog reset");
    chk_irq_flag_read: assert property (o_irq && rd_ctrl && !$past(i_bus.wr)
        && !$past(i_standby) |=> o_rdata[7:6] == 2'b10)
        else $error("interrupt without overflow flag in interval mode");
    chk_ctrl_rsvd_ones: assert property (rd_ctrl |=> o_rdata[4:3] == 2'b11)
        else $error("control reserved bits not one");
    chk_rst_rsvd_ones: assert property (rd_rst |=> o_rdata[5:0] == 6'h3F)
        else $error("reset control reserved bits not one");
    chk_unmapped_zero: assert property (rd_none |=> o_rdata == 8'h00)
        else $error("unmapped read not zero");
    chk_rdata_holds: assert property (!i_bus.rd |=> $stable(o_rdata))
        else $error("read data changed without read");
    cov_chip_rst: cover property ($rose(o_chip_reset));
    cov_pin_low: cover property ($fell(o_reset_output_pin_b));
    cov_irq: cover property ($rose(o_irq));
endmodule

bind wdit_timer wdit_timer_assertions i_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_standby(i_standby), .i_bus(i_bus), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_chip_reset(o_chip_reset), .o_reset_output_pin_b(o_reset_output_pin_b));

/* File: verification/wdit_timer_tb.sv */
// Self-checking bench for the watchdog / interval timer
`timescale 1ns/10ps
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
    $display("[FAIL] %0t got %h want %h", $time, got, exp); end end
module wdit_timer_tb;
    logic                i_clk = 1'b0;
    logic                i_rst_b = 1'b0;
    logic                i_standby = 1'b0;
    wdit_pkg::wdit_bus_t i_bus = '0;
    logic [7:0]          o_rdata;
    logic                o_irq;
    logic                o_chip_reset;
    logic                o_reset_output_pin_b;
    int                  n_mismatch = 0;
    int                  tests_run = 0;
    int                  n_hi;
    int                  n_lo;
    always #20 i_clk = ~i_clk;
    wdit_timer i_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_standby(i_standby),
        .i_bus(i_bus), .o_rdata(o_rdata), .o_irq(o_irq), .o_chip_reset(o_chip_reset),
        .o_reset_output_pin_b(o_reset_output_pin_b));
    // ----------------------------------------
    // Bus tasks, inputs change on falling edge
    // ----------------------------------------
    task automatic wr16(input logic [15:0] a, input logic [15:0] d, input logic w);
        @(negedge i_clk);
        i_bus = '{wr: 1'b1, word: w, rd: 1'b0, addr: a, wdata: d};
        @(negedge i_clk);
        i_bus.wr = 1'b0;
    endtask
    // Samples two edges later so either read latency lands
    task automatic rd8(input logic [15:0] a, input logic [7:0] e);
        @(negedge i_clk);
        i_bus.rd = 1'b1;
        i_bus.addr = a;
        @(negedge i_clk);
        i_bus.rd = 1'b0;
        @(negedge i_clk);
        `CHK(o_rdata, e)
    endtask
    task automatic finish_test();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask
    // Bounded wait: 0 for interrupt, 1 for internal reset
    task automatic wait_for(input int which);
        for (int i = 0; i < 2000; i++) begin
            @(negedge i_clk);
            if ((which == 0 ? o_irq : o_chip_reset) === 1'b1) return;
        end
        n_mismatch++;
        $display("[FAIL] %0t wait bound exhausted", $time);
        finish_test();
    endtask
    // Counts cycles of internal reset and of the low pin, bounded
    task automatic measure_reset();
        n_hi = 0;
        n_lo = 0;
        while (o_chip_reset === 1'b1 && n_hi < 600) begin
            n_hi++;
            if (o_reset_output_pin_b === 1'b0) n_lo++;
            @(negedge i_clk);
        end
        if (n_hi >= 600) begin
            n_mismatch++;
            $display("[FAIL] %0t reset pulse bound exhausted", $time);
            finish_test();
        end
    endtask
    initial begin
        repeat (4) @(negedge i_clk);
        i_rst_b = 1'b1;
        rd8(16'hFFA8, 8'h18);
        rd8(16'hFFA9, 8'h00);
        rd8(16'hFFAB, 8'h3F);
        rd8(16'hFFAA, 8'h00);
        $display("reset values done");
        // Refused writes; counter stays zero while disabled
        wr16(16'hFFA8, 16'hA5_20, 1'b0);
        wr16(16'hFFA8, 16'h3C_20, 1'b1);
        rd8(16'hFFA8, 8'h18);
        wr16(16'hFFA8, 16'h5A_37, 1'b1);
        rd8(16'hFFA9, 8'h00);
        $display("refused writes done");
        // Interval mode at the fastest tap
        wr16(16'hFFA8, 16'hA5_20, 1'b1);
        wr16(16'hFFA8, 16'h5A_FD, 1'b1);
        wait_for(0);
        rd8(16'hFFA8, 8'hB8);
        rd8(16'hFFA9, 8'h02);
        wr16(16'hFFA8, 16'hA5_A0, 1'b1);
        `CHK(o_irq, 1'b1)
        wr16(16'hFFA8, 16'hA5_20, 1'b1);
        @(negedge i_clk);
        `CHK(o_irq, 1'b0)
        wr16(16'hFFA8, 16'hA5_00, 1'b1);
        $display("interval test done");
        // Watchdog mode with reset output enabled
        wr16(16'hFFAA, 16'h5A_40, 1'b1);
        rd8(16'hFFAB, 8'h7F);
        wr16(16'hFFA8, 16'hA5_60, 1'b1);
        wr16(16'hFFA8, 16'h5A_FD, 1'b1);
        wait_for(1);
        measure_reset();
        `CHK(n_hi, 518)
        `CHK(n_lo, 132)
        rd8(16'hFFAB, 8'hFF);
        rd8(16'hFFA8, 8'h18);
        wr16(16'hFFAA, 16'hA5_00, 1'b1);
        rd8(16'hFFAB, 8'h7F);
        $display("watchdog test done");
        // Reset output disabled, then the pin reset clears the flag
        wr16(16'hFFAA, 16'h5A_00, 1'b1);
        wr16(16'hFFA8, 16'hA5_60, 1'b1);
        wr16(16'hFFA8, 16'h5A_FD, 1'b1);
        wait_for(1);
        measure_reset();
        `CHK(n_hi, 518)
        `CHK(n_lo, 0)
        rd8(16'hFFAB, 8'hBF);
        @(negedge i_clk);
        i_rst_b = 1'b0;
        repeat (4) @(negedge i_clk);
        i_rst_b = 1'b1;
        rd8(16'hFFAB, 8'h3F);
        $display("reset output disabled test done");
        // Standby clears mode bits but keeps clock select
        wr16(16'hFFA8, 16'hA5_27, 1'b1);
        rd8(16'hFFA8, 8'h3F);
        @(negedge i_clk);
        i_standby = 1'b1;
        @(negedge i_clk);
        i_standby = 1'b0;
        rd8(16'hFFA8, 8'h1F);
        rd8(16'hFFA9, 8'h00);
        $display("standby test done");
        finish_test();
    end
endmodule
